// file: seq_ctl_pkg.sv
// Purpose: shared constants for the conversion sequence start control
// Assumes: 8-bit register port, 4-bit word address
// Notes:   offsets are word addresses on the plain register port
package seq_ctl_pkg;
  localparam logic [3:0] OFS_ROLLOVER  = 4'h0;
  localparam logic [3:0] OFS_CONFIG    = 4'h4;
  localparam logic [3:0] OFS_SEQ_CTL   = 4'h5;
  localparam logic [3:0] OFS_STATUS    = 4'h6;
  localparam int         CTL_RJ_BIT    = 7;
  localparam int         CTL_SGN_BIT   = 6;
  localparam int         CTL_SCAN_BIT  = 5;
  localparam int         CTL_MULTI_CHANNEL_SELECT_BIT  = 4;
  localparam int         CFG_ETRIG_BIT = 7;
  localparam int         CFG_LRES_BIT  = 6;
  localparam int         STS_DONE_BIT  = 7;
  localparam int         STS_BUSY_BIT  = 6;
  localparam logic [7:0] SEQ_CTL_RST   = 8'h00;
  localparam logic [7:0] CONFIG_RST    = 8'h00;
  localparam logic [3:0] ROLLOVER_RST  = 4'hF;
  localparam logic [3:0] CH_LAST       = 4'hF;
  localparam logic [3:0] CH_FIRST      = 4'h0;
  localparam logic [4:0] SEQ_LEN_FULL  = 5'h10;
  localparam logic [4:0] CNT_ONE       = 5'h01;
  localparam logic [4:0] CNT_ZERO      = 5'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ISSUE, ST_CONVERT} seq_state_t;
endpackage : seq_ctl_pkg

// file: seq_ctl_if.sv
// Purpose: carrier between the sequencer and its two helpers
// Assumes: one clock domain, all signals combinational here
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface seq_ctl_if;
  logic       right_justify;
  logic       signed_fmt;
  logic       low_res;
  logic       multi_channel_select;
  logic [9:0] raw;
  logic [15:0] word;
  logic [3:0] cur_ch;
  logic [3:0] start_ch;
  logic [3:0] wrap_ch;
  logic       wrapped;
  logic [3:0] next_ch;
  logic       wrap_now;
  modport fmt  (input right_justify, signed_fmt, low_res, raw, output word);
  modport step (input multi_channel_select, cur_ch, start_ch, wrap_ch, wrapped,
                output next_ch, wrap_now);
  modport ctl  (output right_justify, signed_fmt, low_res, raw, multi_channel_select,
                cur_ch, start_ch, wrap_ch, wrapped,
                input word, next_ch, wrap_now);
endinterface : seq_ctl_if
`default_nettype wire

// file: result_formatter.sv
// Purpose: maps a raw conversion code onto the 16-bit result word
// Assumes: an 8-bit code arrives msb-aligned in raw bits 9:2
// Notes:   pure combinational
`timescale 1ns/10ps
`default_nettype none
module result_formatter
  import seq_ctl_pkg::*;
(
  seq_ctl_if.fmt f
);
  logic [7:0] code8;
  logic [9:0] code10;

  always_comb
  begin
    code8  = f.raw[9:2];
    code10 = f.raw;
    if (f.right_justify)
    begin
      // right justified is always unsigned
      f.word = f.low_res ? {8'h00, code8} : {6'h00, code10}; // [R6] [R14]
    end
    else
    begin
      // two's complement here is just the msb flipped
      code8[7]  = code8[7] ^ f.signed_fmt;   // [R5] [R15]
      code10[9] = code10[9] ^ f.signed_fmt;  // [R15]
      f.word = f.low_res ? {code8, 8'h00} : {code10, 6'h00}; // [R14] [R17]
    end
  end
endmodule : result_formatter
`default_nettype wire

// file: channel_stepper.sv
// Purpose: picks the channel for the next conversion of a sequence
// Assumes: wrapped tells whether this sequence has already wrapped once
// Notes:   pure combinational
`timescale 1ns/10ps
`default_nettype none
module channel_stepper
  import seq_ctl_pkg::*;
(
  seq_ctl_if.step s
);
  logic early_start;

  always_comb
  begin
    // starting above the rollover channel defers the first wrap to 15
    early_start = (s.start_ch > s.wrap_ch) && !s.wrapped; // [R13]
    s.wrap_now  = s.multi_channel_select && ((s.cur_ch == CH_LAST)
                  || ((s.cur_ch == s.wrap_ch) && !early_start)); // [R12]
    if (!s.multi_channel_select)
      s.next_ch = s.cur_ch; // [R9]
    else if (s.wrap_now)
      s.next_ch = CH_FIRST; // [R12]
    else
      s.next_ch = s.cur_ch + 4'h1; // [R12]
  end
endmodule : channel_stepper
`default_nettype wire

// file: adc_sequence_start_control.sv
// Purpose: conversion sequence start and channel selection control
// Assumes: conv_done_in pulses once per finished conversion
// Notes:   register port answers every access, unmapped reads give zero
//
// What this block does
// [R1] control write aborts and restarts a sequence
// [R2] triggers start sequences only after control write
// [R3] start pulse marks beginning of sampling
// [R4] bit 7 selects right justification
// [R5] bit 6 selects two's complement results
// [R6] right justified results always unsigned
// [R7] bit 5 repeats sequences continuously
// [R8] trigger mode ignores scan, one sequence
// [R9] single mode keeps the one channel
// [R10] multi mode converts sequence-length channels
// [R11] bits 3:0 give the input channel number
// [R12] channels increment, wrap after rollover channel
// [R13] start above rollover wraps after 15
// [R14] result word bit placement per format
// [R15] signed code is unsigned with msb inverted
// [R16] control register readable and writable anytime
// [R17] resolution bit picks 8 or 10 bits
// [R18] control write clears sequence done flag
// [R19] control write clears conversion counter
// [R20] last written settings reused for later sequences
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_start_control
  import seq_ctl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        ext_trig_in,
  input  wire logic        conv_done_in,
  input  wire logic [9:0]  raw_result_in,
  output logic             sample_start_out,
  output logic             abort_out,
  output logic      [3:0]  channel_out,
  output logic      [15:0] result_word_out,
  output logic      [3:0]  result_index_out,
  output logic             result_valid_out,
  output logic             seq_done_out
);
  seq_state_t  state_r;
  logic [7:0]  seq_ctl_r;
  logic [7:0]  config_r;
  logic [3:0]  rollover_r;
  logic [3:0]  chan_r;
  logic        wrapped_r;
  logic [4:0]  conv_cnt_r;
  logic        done_r;
  logic [7:0]  rdata_r;
  logic [15:0] result_r;
  logic [3:0]  result_idx_r;
  logic        result_vld_r;
  logic        ctl_wr;
  logic        trig_go;
  logic        conv_end;
  logic        seq_last;
  logic        etrig_en;
  logic [4:0]  seq_len;
  logic [7:0]  status_val;

  seq_ctl_if bus_if ();

  result_formatter u_fmt (
    .f (bus_if.fmt)
  );

  channel_stepper u_step (
    .s (bus_if.step)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb
  begin
    ctl_wr     = wr_in && hit(addr_in, OFS_SEQ_CTL); // [R1] [R16]
    etrig_en   = config_r[CFG_ETRIG_BIT];
    trig_go    = (state_r == ST_ARMED) && ext_trig_in; // [R2]
    conv_end   = (state_r == ST_CONVERT) && conv_done_in;
    // zero in the length field means a full 16-conversion sequence
    seq_len    = (config_r[3:0] == 4'h0) ? SEQ_LEN_FULL
                 : {1'b0, config_r[3:0]}; // [R10]
    seq_last   = (conv_cnt_r + CNT_ONE) == seq_len; // [R10]
    status_val = {done_r, (state_r == ST_ISSUE) || (state_r == ST_CONVERT),
                  2'b00, conv_cnt_r[3:0]};
  end

  always_comb
  begin
    bus_if.right_justify = seq_ctl_r[CTL_RJ_BIT]; // [R4]
    bus_if.signed_fmt    = seq_ctl_r[CTL_SGN_BIT]; // [R5]
    bus_if.low_res       = config_r[CFG_LRES_BIT]; // [R17]
    bus_if.raw           = raw_result_in;
    bus_if.multi_channel_select          = seq_ctl_r[CTL_MULTI_CHANNEL_SELECT_BIT];
    bus_if.cur_ch        = chan_r;
    bus_if.start_ch      = seq_ctl_r[3:0];
    bus_if.wrap_ch       = rollover_r;
    bus_if.wrapped       = wrapped_r;
  end

  // settings registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      seq_ctl_r  <= SEQ_CTL_RST;
      config_r   <= CONFIG_RST;
      rollover_r <= ROLLOVER_RST;
    end
    else if (wr_in)
    begin
      if (hit(addr_in, OFS_SEQ_CTL))
        seq_ctl_r <= wdata_in; // [R16] [R20]
      if (hit(addr_in, OFS_CONFIG))
        config_r <= wdata_in;
      if (hit(addr_in, OFS_ROLLOVER))
        rollover_r <= wdata_in[3:0];
    end
  end

  // sequence state machine
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_r <= ST_IDLE;
    else if (ctl_wr)
      state_r <= etrig_en ? ST_ARMED : ST_ISSUE; // [R1] [R2]
    else
    begin
      unique case (state_r)
        ST_IDLE:    state_r <= ST_IDLE;
        ST_ARMED:   state_r <= trig_go ? ST_ISSUE : ST_ARMED; // [R2]
        ST_ISSUE:   state_r <= ST_CONVERT; // [R3]
        ST_CONVERT:
        begin
          if (conv_done_in && !seq_last)
            state_r <= ST_ISSUE;
          else if (conv_done_in && etrig_en)
            state_r <= ST_ARMED; // [R8]
          else if (conv_done_in)
            state_r <= seq_ctl_r[CTL_SCAN_BIT] ? ST_ISSUE : ST_IDLE; // [R7]
        end
      endcase
    end
  end

  // channel and wrap tracking
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      chan_r    <= CH_FIRST;
      wrapped_r <= 1'b0;
    end
    else if (ctl_wr)
    begin
      chan_r    <= wdata_in[3:0]; // [R11]
      wrapped_r <= 1'b0;
    end
    else if (trig_go || (conv_end && seq_last))
    begin
      chan_r    <= seq_ctl_r[3:0]; // [R11] [R20]
      wrapped_r <= 1'b0;
    end
    else if (conv_end)
    begin
      chan_r    <= bus_if.next_ch; // [R9] [R12]
      wrapped_r <= wrapped_r || bus_if.wrap_now; // [R13]
    end
  end

  // conversion counter, zero at begin and end of every sequence
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      conv_cnt_r <= CNT_ZERO;
    else if (ctl_wr || trig_go)
      conv_cnt_r <= CNT_ZERO; // [R19]
    else if (conv_end)
      conv_cnt_r <= seq_last ? CNT_ZERO : conv_cnt_r + CNT_ONE; // [R10]
  end

  // done flag: completion beats a same-cycle write-one clear
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      done_r <= 1'b0;
    else if (ctl_wr)
      done_r <= 1'b0; // [R18]
    else if (conv_end && seq_last)
      done_r <= 1'b1;
    else if (wr_in && hit(addr_in, OFS_STATUS) && wdata_in[STS_DONE_BIT])
      done_r <= 1'b0;
  end

  // result word
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      result_r     <= 16'h0000;
      result_idx_r <= 4'h0;
      result_vld_r <= 1'b0;
    end
    else
    begin
      result_vld_r <= conv_end;
      if (conv_end)
      begin
        result_r     <= bus_if.word; // [R14]
        result_idx_r <= conv_cnt_r[3:0];
      end
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_r <= 8'h00;
    else if (!rd_in)
      rdata_r <= 8'h00;
    else if (hit(addr_in, OFS_SEQ_CTL))
      rdata_r <= seq_ctl_r; // [R16]
    else if (hit(addr_in, OFS_CONFIG))
      rdata_r <= config_r;
    else if (hit(addr_in, OFS_ROLLOVER))
      rdata_r <= {4'h0, rollover_r};
    else if (hit(addr_in, OFS_STATUS))
      rdata_r <= status_val;
    else
      rdata_r <= 8'h00;
  end

  assign rdata_out        = rdata_r;
  assign sample_start_out = (state_r == ST_ISSUE); // [R3]
  assign abort_out        = ctl_wr;
  assign channel_out      = chan_r;
  assign result_word_out  = result_r;
  assign result_index_out = result_idx_r;
  assign result_valid_out = result_vld_r;
  assign seq_done_out     = done_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_write_restarts: assert property ( // [R1]
    ctl_wr |=> (state_r == ST_ISSUE) || (state_r == ST_ARMED))
    else $error("control write did not restart the sequence");

  a_trig_needs_arm: assert property ( // [R2]
    (state_r == ST_IDLE) && !ctl_wr |=> state_r != ST_ISSUE)
    else $error("sequence started without an arming write");

  a_start_is_sample: assert property ( // [R3]
    sample_start_out && !ctl_wr
    |=> !sample_start_out && (state_r == ST_CONVERT))
    else $error("start pulse not followed by conversion phase");

  a_right_unsigned: assert property ( // [R6]
    conv_end && seq_ctl_r[CTL_RJ_BIT] && !config_r[CFG_LRES_BIT]
    |=> result_word_out == {6'h00, $past(raw_result_in)})
    else $error("right justified 10-bit result misplaced");

  a_signed_msb_flip: assert property ( // [R15]
    conv_end && !seq_ctl_r[CTL_RJ_BIT] && seq_ctl_r[CTL_SGN_BIT]
    && config_r[CFG_LRES_BIT]
    |=> result_word_out == {~$past(raw_result_in[9]),
                            $past(raw_result_in[8:2]), 8'h00})
    else $error("signed 8-bit left result wrong");

  a_single_channel: assert property ( // [R9]
    sample_start_out && !seq_ctl_r[CTL_MULTI_CHANNEL_SELECT_BIT]
    |-> channel_out == seq_ctl_r[3:0])
    else $error("single channel mode left its channel");

  a_trig_one_seq: assert property ( // [R8]
    conv_end && seq_last && etrig_en && !ctl_wr |=> state_r == ST_ARMED)
    else $error("trigger mode did not wait for next trigger");

  a_write_clears: assert property ( // [R18]
    ctl_wr |=> !done_r && (conv_cnt_r == CNT_ZERO)) // [R19]
    else $error("control write left done flag or counter");

  // an abort in the same cycle loads the newly written channel, a sequence end the start code
  a_wrap_to_zero: assert property ( // [R12]
    conv_end && bus_if.wrap_now && !seq_last && !ctl_wr
    |=> channel_out == CH_FIRST)
    else $error("multi channel sequence did not wrap to input 0");

  a_scan_restart: assert property ( // [R7]
    conv_end && seq_last && seq_ctl_r[CTL_SCAN_BIT] && !etrig_en && !ctl_wr
    |=> sample_start_out)
    else $error("scan mode did not start the next sequence");

  c_single_seq: cover property (conv_end && seq_last && !etrig_en);
  c_scan: cover property (conv_end && seq_last && seq_ctl_r[CTL_SCAN_BIT]);
  c_trig_start: cover property (trig_go);
  c_multi_wrap: cover property (conv_end && bus_if.wrap_now);
  c_abort_busy: cover property (ctl_wr && (state_r == ST_CONVERT));
endmodule : adc_sequence_start_control
`default_nettype wire

// file: conv_model.sv
// Purpose: converter stand-in that answers each sampling start
// Assumes: one start at a time, an abort cancels the running one
// Notes:   raw code changes every cycle, only valid in the done cycle
`timescale 1ns/10ps
`default_nettype none
module conv_model
(
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic       abort_in,
  input  wire logic [3:0] dly_in,
  output logic            done_out,
  output logic      [9:0] raw_out
);
  logic [3:0] cnt_r;
  int         seed_r;
  initial
  begin
    cnt_r    = 4'h0;
    done_out = 1'b0;
    raw_out  = 10'h000;
    seed_r   = 82581;
  end
  // sampling begins at the start pulse, so the count starts there
  always @(posedge clk_in)
  begin
    raw_out  <= 10'($random(seed_r));
    done_out <= (cnt_r == 4'h1) && !abort_in && !start_in;
    if (abort_in || start_in)
      cnt_r <= start_in ? dly_in : 4'h0;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule : conv_model
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench for the sequence start control
// Assumes: config written before the first control write that uses it
// Notes:   a monitor predicts channels, indices and result words
`timescale 1ns/10ps
`default_nettype none
module tb;
  import seq_ctl_pkg::*;
  logic        clk_in, rst_in, wr, rd, trig, done, sstart, abrt;
  logic        rvalid, sdone, etrig, lres;
  logic [3:0]  addr, dly, ch, ridx, len, roll, exp_ch;
  logic [7:0]  wdata, rdata, ctl;
  logic [9:0]  raw, raw_q;
  logic [15:0] rword;
  logic        wrapped;
  int          failures, total_checks, n_res, n_starts, idx, seed, i, k, n0;

  adc_sequence_start_control i_adc_sequence_start_control (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_trig_in(trig),
    .conv_done_in(done), .raw_result_in(raw), .sample_start_out(sstart),
    .abort_out(abrt), .channel_out(ch), .result_word_out(rword),
    .result_index_out(ridx), .result_valid_out(rvalid),
    .seq_done_out(sdone));
  conv_model i_conv_model (.clk_in(clk_in), .start_in(sstart),
    .abort_in(abrt), .dly_in(dly), .done_out(done), .raw_out(raw));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic int slen();
    return (len == 4'h0) ? 16 : int'(len);
  endfunction : slen

  // justification first: right justified ignores the sign select
  function automatic logic [15:0] fmt(input logic [9:0] r);
    if (lres)
      return ctl[CTL_RJ_BIT] ? {8'h00, r[9:2]}
                             : {r[9] ^ ctl[CTL_SGN_BIT], r[8:2], 8'h00};
    return ctl[CTL_RJ_BIT] ? {6'h00, r}
                           : {r[9] ^ ctl[CTL_SGN_BIT], r[8:0], 6'h00};
  endfunction : fmt

  always @(posedge clk_in)
  begin
    chk(16'(abrt), 16'(wr && addr == OFS_SEQ_CTL));
    if (rvalid)
    begin
      chk(rword, fmt(raw_q));
      chk(16'(ridx), 16'(idx));
      idx++;
      n_res++;
      if (idx == slen())
      begin
        idx = 0;
        exp_ch = ctl[3:0];
        wrapped = 1'b0;
      end
    end
    if (sstart)
    begin
      chk(16'(ch), 16'(exp_ch));
      n_starts++;
      if (ctl[CTL_MULTI_CHANNEL_SELECT_BIT])
      begin
        if (exp_ch == 4'hF ||
            (exp_ch == roll && !(ctl[3:0] > roll && !wrapped)))
        begin
          exp_ch = 4'h0;
          wrapped = 1'b1;
        end
        else
          exp_ch = exp_ch + 4'h1;
      end
    end
    if (done)
      raw_q = raw;
    if (wr && addr == OFS_ROLLOVER)
      roll = wdata[3:0];
    if (wr && addr == OFS_SEQ_CTL)
    begin
      ctl = wdata;
      exp_ch = wdata[3:0];
      wrapped = 1'b0;
      idx = 0;
      n_res = 0;
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(16'(rdata), 16'(exp));
  endtask : rd_reg

  task automatic set_cfg(input logic e, input logic l, input logic [3:0] n);
    etrig = e;
    lres = l;
    len = n;
    wr_reg(OFS_CONFIG, {e, l, 2'h0, n});
  endtask : set_cfg

  task automatic wait_res(input int n);
    for (k = 0; k < 3000 && n_res < n; k++)
      @(posedge clk_in);
    if (k == 3000)
    begin
      failures++;
      end_of_test();
    end
  endtask : wait_res

  task automatic run(input logic [7:0] c);
    wr_reg(OFS_SEQ_CTL, c);
    #1 chk(16'(sdone), 16'h0000);
    rd_reg(OFS_SEQ_CTL, c);
    for (k = 0; k < 3000 && sdone !== 1'b1; k++)
      @(posedge clk_in);
    if (k == 3000)
    begin
      failures++;
      end_of_test();
    end
    @(posedge clk_in);
    #1 chk(16'(n_res), 16'(slen()));
  endtask : run

  initial
  begin
    seed = 82581;
    rst_in = 1'b1;
    {wr, rd, trig, addr, wdata, lres, etrig, len} = '0;
    {n_res, n_starts, idx, failures, total_checks} = '0;
    {ctl, exp_ch, wrapped, raw_q} = '0;
    roll = ROLLOVER_RST;
    dly = 4'h1;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_reg(OFS_SEQ_CTL, SEQ_CTL_RST);
    rd_reg(4'h9, 8'h00);
    set_cfg(1'b0, 1'b0, 4'h0);
    wr_reg(OFS_ROLLOVER, 8'h03);
    run(8'h1E);
    run(8'hD2);
    rd_reg(OFS_STATUS, 8'h80);
    for (i = 0; i < 14; i++)
    begin
      dly <= 4'h1 + 4'($random(seed) & 7);
      set_cfg(1'b0, 1'($random(seed)), 4'($random(seed)));
      wr_reg(OFS_ROLLOVER, 8'($random(seed)));
      run(8'($random(seed)) & 8'hDF);
    end
    // slow conversions keep every abort clear of a done pulse
    dly <= 4'h6;
    // abort in mid sequence, then restart on another channel
    set_cfg(1'b0, 1'b0, 4'h8);
    wr_reg(OFS_SEQ_CTL, 8'h10);
    wait_res(2);
    run(8'h17);
    set_cfg(1'b0, 1'b0, 4'h2);
    run(8'h35);
    n0 = n_starts;
    wait_res(4);
    chk(16'(n_starts > n0), 16'h0001);
    // stop the scan before the trigger mode is set up
    run(8'h12);
    // triggers are refused until the control write arms them
    set_cfg(1'b1, 1'b0, 4'h2);
    n0 = n_starts;
    @(posedge clk_in) trig <= 1'b1;
    @(posedge clk_in) trig <= 1'b0;
    wr_reg(OFS_SEQ_CTL, 8'h32);
    repeat (20) @(posedge clk_in);
    chk(16'(n_starts), 16'(n0));
    for (i = 1; i <= 2; i++)
    begin
      @(posedge clk_in) trig <= 1'b1;
      @(posedge clk_in) trig <= 1'b0;
      wait_res(2 * i);
      repeat (20) @(posedge clk_in);
      chk(16'(n_res), 16'(2 * i));
    end
    end_of_test();
  end
endmodule : tb
`default_nettype wire
